// ===== rtl/tsl_map.vh
// Register offsets, field positions and reset values of the two-wire slave core.
`ifndef TSL_MAP_VH
`define TSL_MAP_VH
`define TSL_ADDR_W          3
`define TSL_OFF_RCV         3'h0
`define TSL_OFF_TRN         3'h1
`define TSL_OFF_BRG         3'h2
`define TSL_OFF_CON         3'h3
`define TSL_OFF_STAT        3'h4
`define TSL_OFF_ADD         3'h5
`define TSL_CON_EN          15
`define TSL_CON_CLK_REL     12
`define TSL_CON_TEN_SEL     10
`define TSL_STAT_TBF        0
`define TSL_STAT_RX_FULL    1
`define TSL_STAT_RW         2
`define TSL_STAT_TEN_MATCH  3
`define TSL_STAT_SIF        4
`define TSL_STAT_OV         6
`define TSL_STAT_RO_MASK    16'h003f
`define TSL_CON_RST         16'h1000
`define TSL_STAT_RST        16'h0000
`define TSL_ADD_RST         10'h000
`define TSL_BRG_RST         9'h000
`define TSL_TEN_PATTERN     5'h1e
`endif

// ===== rtl/tsl_slave.v
// Two-wire bus slave core: registers, address recognition, transmit and receive.
// Behaviour
// - Idle until start, then shift address byte
// - Sample serial bits on rising clock edge
// - Seven-bit: address 6:0 versus shift 7:1
// - Ten-bit mode select at control bit 10
// - Match acks, flags interrupt, buffer untouched
// - Read direction: transmit, ack, hold clock low
// - Release clock, shift eight bits on falls
// - Transmit interrupt at ninth fall regardless of ack
// - Write direction: receive, buffer if free, ack
// - Buffer full: no ack, keep buffer, interrupt
// - Overflow only: load buffer, answer no ack
// - Received byte moves to buffer; single transmit
// - Ten-bit first byte: 11110 and bits 9:8
// - First byte match write pulses, clears flag
// - Second byte matches 7:0, sets match flag
// - After repeated start only first byte matters
// - Control full access; status low six read-only
// - Slave address register is ten bits
// - Baud reload register holds nine bits
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "tsl_map.vh"
module tsl_slave (
  input  wire                   core_clk,
  input  wire                   reset_n,
  input  wire [`TSL_ADDR_W-1:0] reg_addr,
  input  wire [15:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [15:0]            reg_rdata,
  input  wire                   scl_in,
  output reg                    scl_out,
  output reg                    scl_oe,
  input  wire                   sda_in,
  output reg                    sda_out,
  output reg                    sda_oe,
  output reg                    slave_irq_pulse,
  output reg  [8:0]             baud_reload_out
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ADR2 = 3'h2;
  localparam ST_RX   = 3'h3;
  localparam ST_TX   = 3'h4;
  localparam ST_ACK  = 3'h5;
  localparam ST_TACK = 3'h6;

  reg  [1:0]  scl_sync_ff;
  reg  [1:0]  sda_sync_ff;
  reg         scl_d_ff;
  reg         sda_d_ff;
  reg  [15:0] link_control_ff;
  reg  [15:0] link_status_ff;
  reg  [9:0]  own_slave_address_ff;
  reg  [7:0]  receive_buffer_ff;
  reg  [7:0]  transmit_holding_ff;
  reg  [7:0]  shift_register_ff;
  reg  [2:0]  state_ff;
  reg  [3:0]  bit_cnt_ff;
  reg         ack_drive_ff;
  reg         after_ack_ff;
  reg         prior_match_ff;
  reg  [2:0]  ack_next_ff;

  wire scl_s = scl_sync_ff[1];
  wire sda_s = sda_sync_ff[1];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire enabled = link_control_ff[`TSL_CON_EN];
  wire ten_bit = link_control_ff[`TSL_CON_TEN_SEL];
  wire rx_full = link_status_ff[`TSL_STAT_RX_FULL];
  wire ovf = link_status_ff[`TSL_STAT_OV];
  wire [7:0] next_shift = {shift_register_ff[6:0], sda_s};

  // Address byte decode, used for seven-bit, ten-bit first and second bytes.
  function [1:0] addr_match;
    input [7:0] sh;
    input [9:0] own;
    input       ten;
    input       second;
    begin
      if (second) begin
        addr_match = {1'b0, sh == own[7:0]};
      end else if (ten) begin
        addr_match = {1'b1, sh[7:3] == `TSL_TEN_PATTERN && sh[2:1] == own[9:8]};
      end else begin
        addr_match = {1'b0, sh[7:1] == own[6:0]};
      end
    end
  endfunction

  wire [1:0] am = addr_match(next_shift, own_slave_address_ff, ten_bit, state_ff == ST_ADR2);
  wire sw_trn = reg_wr && reg_addr == `TSL_OFF_TRN;
  wire sw_rcv = reg_rd && reg_addr == `TSL_OFF_RCV;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_d_ff    <= scl_s;
      sda_d_ff    <= sda_s;
    end
  end

  // ack_next_ff codes what follows the ninth bit: 0 idle, 1 rx, 2 tx, 3 second byte.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_control_ff      <= `TSL_CON_RST;
      link_status_ff       <= `TSL_STAT_RST;
      own_slave_address_ff <= `TSL_ADD_RST;
      receive_buffer_ff    <= 8'h00;
      transmit_holding_ff  <= 8'h00;
      baud_reload_out      <= `TSL_BRG_RST;
      shift_register_ff    <= 8'h00;
      state_ff             <= ST_IDLE;
      bit_cnt_ff           <= 4'h0;
      ack_drive_ff         <= 1'b0;
      after_ack_ff         <= 1'b0;
      prior_match_ff       <= 1'b0;
      ack_next_ff          <= 3'h0;
      slave_irq_pulse      <= 1'b0;
      reg_rdata            <= 16'h0000;
      scl_out              <= 1'b0;
      scl_oe               <= 1'b0;
      sda_out              <= 1'b0;
      sda_oe               <= 1'b0;
    end else begin
      slave_irq_pulse <= 1'b0;
      reg_rdata       <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `TSL_OFF_RCV:  reg_rdata <= {8'h00, receive_buffer_ff};
          `TSL_OFF_TRN:  reg_rdata <= {8'h00, transmit_holding_ff};
          `TSL_OFF_BRG:  reg_rdata <= {7'h00, baud_reload_out};
          `TSL_OFF_CON:  reg_rdata <= link_control_ff;
          `TSL_OFF_STAT: reg_rdata <= link_status_ff;
          `TSL_OFF_ADD:  reg_rdata <= {6'h00, own_slave_address_ff};
          default:       reg_rdata <= 16'h0000;
        endcase
      end
      if (reg_wr) begin
        case (reg_addr)
          `TSL_OFF_TRN: begin
            transmit_holding_ff <= reg_wdata[7:0];
            link_status_ff[`TSL_STAT_TBF] <= 1'b1;
          end
          `TSL_OFF_BRG:  baud_reload_out <= reg_wdata[8:0];
          `TSL_OFF_CON:  link_control_ff <= reg_wdata;
          `TSL_OFF_STAT: link_status_ff <= (link_status_ff & `TSL_STAT_RO_MASK) |
                                           (reg_wdata & ~`TSL_STAT_RO_MASK);
          `TSL_OFF_ADD:  own_slave_address_ff <= reg_wdata[9:0];
          default: ;
        endcase
      end
      // Reading the buffer empties it; a hardware load later in this block wins.
      if (sw_rcv) begin
        link_status_ff[`TSL_STAT_RX_FULL] <= 1'b0;
      end
      if (!enabled || stop_det) begin
        state_ff     <= ST_IDLE;
        ack_drive_ff <= 1'b0;
        after_ack_ff <= 1'b0;
        if (!enabled) begin
          prior_match_ff <= 1'b0;
        end
      end else if (start_det) begin
        state_ff     <= ST_ADDR;
        bit_cnt_ff   <= 4'h0;
        ack_drive_ff <= 1'b0;
        after_ack_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: ;
          ST_ADDR, ST_ADR2, ST_RX: begin
            if (scl_rise) begin
              shift_register_ff <= next_shift;
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h7) begin
                state_ff <= ST_ACK;
                if (state_ff == ST_RX) begin
                  ack_next_ff <= 3'h1;
                  ack_drive_ff <= !rx_full && !ovf;
                  if (!rx_full) begin
                    receive_buffer_ff <= next_shift;
                    link_status_ff[`TSL_STAT_RX_FULL] <= 1'b1;
                  end else begin
                    link_status_ff[`TSL_STAT_OV] <= 1'b1;
                  end
                end else if (am[0] && am[1] && prior_match_ff && next_shift[0]) begin
                  ack_drive_ff <= 1'b1;
                  ack_next_ff <= 3'h2;
                  link_status_ff[`TSL_STAT_RW] <= 1'b1;
                end else if (am[0] && am[1] && !next_shift[0]) begin
                  ack_drive_ff <= 1'b1;
                  ack_next_ff <= 3'h3;
                  link_status_ff[`TSL_STAT_TEN_MATCH] <= 1'b0;
                  link_status_ff[`TSL_STAT_RW] <= 1'b0;
                end else if (am[0] && !am[1]) begin
                  ack_drive_ff <= 1'b1;
                  if (state_ff == ST_ADR2) begin
                    ack_next_ff <= 3'h1;
                    prior_match_ff <= 1'b1;
                    link_status_ff[`TSL_STAT_TEN_MATCH] <= 1'b1;
                  end else begin
                    ack_next_ff <= next_shift[0] ? 3'h2 : 3'h1;
                    link_status_ff[`TSL_STAT_RW] <= next_shift[0];
                  end
                end else begin
                  ack_drive_ff <= 1'b0;
                  ack_next_ff <= 3'h0;
                  prior_match_ff <= 1'b0;
                  link_status_ff[`TSL_STAT_TEN_MATCH] <= 1'b0;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall && !after_ack_ff) begin
              after_ack_ff <= 1'b1;
            end else if (scl_fall) begin
              after_ack_ff <= 1'b0;
              ack_drive_ff <= 1'b0;
              bit_cnt_ff   <= 4'h0;
              if (ack_next_ff != 3'h0) begin
                slave_irq_pulse <= 1'b1;
                link_status_ff[`TSL_STAT_SIF] <= 1'b1;
              end
              case (ack_next_ff)
                3'h1: state_ff <= ST_RX;
                3'h2: begin
                  state_ff <= ST_TX;
                  link_control_ff[`TSL_CON_CLK_REL] <= 1'b0;
                end
                3'h3: state_ff <= ST_ADR2;
                default: state_ff <= ST_IDLE;
              endcase
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h7) begin
                state_ff <= ST_TACK;
                link_status_ff[`TSL_STAT_TBF] <= 1'b0;
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              ack_next_ff <= sda_s ? 3'h0 : 3'h2;
            end else if (scl_fall) begin
              slave_irq_pulse <= 1'b1;
              link_status_ff[`TSL_STAT_SIF] <= 1'b1;
              bit_cnt_ff <= 4'h0;
              if (ack_next_ff == 3'h2) begin
                state_ff <= ST_TX;
                link_control_ff[`TSL_CON_CLK_REL] <= 1'b0;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
      // The clock is held only once it is sampled low, so a hold never shortens a high phase.
      scl_out <= 1'b0;
      scl_oe  <= enabled && state_ff == ST_TX && bit_cnt_ff == 4'h0 &&
                 !link_control_ff[`TSL_CON_CLK_REL] && !scl_s;
      sda_out <= 1'b0;
      if (state_ff == ST_ACK) begin
        sda_oe <= ack_drive_ff && after_ack_ff;
      end else if (state_ff == ST_TX && link_control_ff[`TSL_CON_CLK_REL]) begin
        sda_oe <= !scl_s ? !transmit_holding_ff[3'h7 - bit_cnt_ff[2:0]] : sda_oe;
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end
  // Both bus lines are only ever pulled low; the pull-ups supply the high level.
endmodule // tsl_slave

// ===== test/tsl_mst.sv
// Behavioural two-wire bus master that pulls the lines low only.
`timescale 1ns/1ps
module tsl_mst (
  input  wire scl_line,
  input  wire sda_line,
  output reg  scl_low,
  output reg  sda_low
);
  localparam Q = 100;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Waiting on the line lets the slave stretch the clock; the bench timeout bounds it.
  task bit_io(input b, output r);
    sda_low = !b;
    #Q scl_low = 1'b0;
    wait (scl_line);
    #(Q + 1) r = sda_line;
    #Q scl_low = 1'b1;
    #Q;
  endtask
  task start;
    #1 sda_low = 1'b0;
    #Q scl_low = 1'b0;
    wait (scl_line);
    #(Q + 1) sda_low = 1'b1;
    #Q scl_low = 1'b1;
    #Q;
  endtask
  task stop;
    #1 sda_low = 1'b1;
    #Q scl_low = 1'b0;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  task send(input [7:0] d, output ack);
    reg r;
    #1;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task recv(input ack, output [7:0] d);
    reg r;
    #1;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule // tsl_mst

// ===== test/tsl_slave_properties.sv
// Port checks for the two-wire slave core.
`timescale 1ns/1ps
module tsl_props (
  input wire        core_clk,
  input wire        reset_n,
  input wire [2:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        scl_in,
  input wire        scl_out,
  input wire        scl_oe,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        slave_irq_pulse,
  input wire [8:0]  baud_reload_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  irq_single_a: assert property (slave_irq_pulse |=> !slave_irq_pulse)
    else $error("interrupt pulse too long");
  irq_on_low_a: assert property (slave_irq_pulse |-> !scl_in)
    else $error("interrupt pulse while clock high");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without read");
  hole_read_a: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  add_width_a: assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata[15:10] == 6'h00)
    else $error("address register too wide");
  brg_load_a: assert property (reg_wr && reg_addr == 3'h2 |=>
    baud_reload_out == $past(reg_wdata[8:0]))
    else $error("reload value not taken");
  brg_read_a: assert property (reg_rd && reg_addr == 3'h2 |=>
    reg_rdata == {7'h00, baud_reload_out})
    else $error("reload readback differs");
  drive_low_a: assert property (!scl_out && !sda_out)
    else $error("bus line driven high");
  sda_on_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  scl_hold_a: assert property ($rose(scl_oe) |-> !scl_in)
    else $error("clock stretch began while high");
  cover property (slave_irq_pulse);
  cover property ($rose(scl_oe));
  cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule // tsl_props
bind tsl_slave tsl_props tsl_props_inst (.core_clk(core_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .slave_irq_pulse(slave_irq_pulse), .baud_reload_out(baud_reload_out));

// ===== test/tsl_slave_tb.sv
// Self-checking bench for the two-wire slave core.
`timescale 1ns/1ps
module tsl_slave_tb;
  logic        core_clk;
  logic        reset_n;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  wire  [15:0] reg_rdata;
  wire  [8:0]  brg;
  wire         scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda;
  wire         scl = (scl_oe ? scl_out : 1'b1) & !m_scl;
  wire         sda = (sda_oe ? sda_out : 1'b1) & !m_sda;
  int          errors, tests_run, cyc;
  logic [15:0] irqs;
  logic [9:0]  a;
  logic [7:0]  d, t;
  logic        k;
  tsl_slave tsl_slave_inst (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .slave_irq_pulse(irq), .baud_reload_out(brg));
  tsl_mst tsl_mst_inst (.scl_line(scl), .sda_line(sda), .scl_low(m_scl), .sda_low(m_sda));
  function [7:0] first10(input [9:0] ad, input rw);
    first10 = {5'h1e, ad[9:8], rw};
  endfunction
  task results;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input [15:0] s, input [15:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [2:0] ad, input [15:0] v);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rc(input string n, input [2:0] ad, input [15:0] e);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask
  task wb(input [7:0] b, input e);
    tsl_mst_inst.send(b, k);
    chk("ack", {15'h0, k}, {15'h0, e});
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (irq)
      irqs <= irqs + 16'h1;
    if (cyc == 60000) begin
      errors++;
      results;
    end
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, reset_n, irqs, cyc} = '0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    a = $urandom(58);
    rc("con", 3'h3, 16'h1000);
    rc("stat", 3'h4, 16'h0000);
    rc("hole", 3'h6, 16'h0000);
    d = $urandom;
    wr(3'h2, {7'h7f, d, 1'b1});
    rc("brg", 3'h2, {7'h0, d, 1'b1});
    chk("brg_out", {7'h0, brg}, {7'h0, d, 1'b1});
    wr(3'h5, 16'hffff);
    rc("add", 3'h5, 16'h03ff);
    wr(3'h4, 16'hffff);
    rc("stat", 3'h4, 16'hffc0);
    wr(3'h4, 16'h0000);
    wr(3'h3, 16'h7fff);
    rc("con", 3'h3, 16'h7fff);
    $display("registers done");
    wr(3'h5, {9'h0, a[6:0]});
    tsl_mst_inst.start;
    wb({a[6:0], 1'b0}, 1'b0);
    tsl_mst_inst.stop;
    wr(3'h3, 16'h9000);
    tsl_mst_inst.start;
    wb({a[6:0] ^ 7'h01, 1'b0}, 1'b0);
    tsl_mst_inst.start;
    wb({a[6:0], 1'b0}, 1'b1);
    rc("stat", 3'h4, 16'h0010);
    d = $urandom;
    wb(d, 1'b1);
    rc("rcv", 3'h0, {8'h0, d});
    t = $urandom;
    wb(t, 1'b1);
    wb(~t, 1'b0);
    rc("stat", 3'h4, 16'h0052);
    rc("rcv", 3'h0, {8'h0, t});
    d = $urandom;
    wb(d, 1'b0);
    rc("rcv", 3'h0, {8'h0, d});
    tsl_mst_inst.stop;
    chk("irq", irqs, 16'h5);
    wr(3'h4, 16'h0000);
    $display("seven-bit receive done");
    tsl_mst_inst.start;
    wb({a[6:0], 1'b1}, 1'b1);
    #2000 chk("hold", {15'h0, scl_oe}, 16'h1);
    t = $urandom;
    wr(3'h1, {8'h0, t});
    wr(3'h3, 16'h9000);
    tsl_mst_inst.recv(1'b0, d);
    chk("tx", {8'h0, d}, {8'h0, t});
    tsl_mst_inst.stop;
    chk("irq", irqs, 16'h7);
    $display("seven-bit transmit done");
    a = $urandom;
    wr(3'h5, {6'h0, a});
    wr(3'h3, 16'h9400);
    tsl_mst_inst.start;
    wb(first10(a, 1'b0), 1'b1);
    wb(a[7:0], 1'b1);
    rc("stat", 3'h4, 16'h0018);
    d = $urandom;
    wb(d, 1'b1);
    rc("rcv", 3'h0, {8'h0, d});
    tsl_mst_inst.start;
    wb(first10(a, 1'b1), 1'b1);
    t = $urandom;
    wr(3'h1, {8'h0, t});
    wr(3'h3, 16'h9400);
    tsl_mst_inst.recv(1'b0, d);
    chk("tx", {8'h0, d}, {8'h0, t});
    tsl_mst_inst.stop;
    tsl_mst_inst.start;
    wb(first10(a ^ 10'h300, 1'b0), 1'b0);
    tsl_mst_inst.stop;
    $display("ten-bit done");
    results;
  end
endmodule // tsl_slave_tb
